/* fuse_cfg_pkg.sv */
// fuse configuration loader constants, register map and carriers
// assumes a register port (address, write strobe, data) driven by an i2c target elsewhere
//
// Contract
// - copy fuses into mirror registers on each rising input undervoltage crossing
// - then move mirror contents into the functional registers
// - mirrors hold defaults; writable only in temporary configuration mode
// - load or selftest failure sets flag, blocks power-up until cleared in quiet off
// - failure flags writable only while enable pin is high
// - with pin high, ignore low-power-off default and go to quiet off
// - in temporary mode selftest flag reports real result, 0 pass 1 fail
// - in temporary mode target address is 0x08, crc and secure write off
// - in temporary mode all watchdog supervision is disabled
// - extended page 1 shows mirrors only in temporary mode, else refused
// - input supply falling below threshold resets mirror registers
// - fuse burning allowed only in temporary mode while in quiet off
// - reference mismatch is critical and blocks regulator power-up
// - mismatch during power-up fails selftest regardless of bypass, only in safety variant
// - drift while on shuts down stages if bypass 0, only interrupt if 1
// - reference fail interrupt latch sets on failure unless masked
// - reference status reads 1 out of range, 0 in range
// - selftest exercises comparators; failing ones set warning bits
// - each check overwrites results; clearing needs secure write when enabled
// - writing 1 to check bit starts a check; bit self-clears on completion
// - fault reporting blanked during on-demand check at most 200 us
package fuse_cfg_pkg;
	localparam int NUM_MIRROR = 9;
	localparam logic [7:0] ADDR_LDO3_CFG = 8'h00_D6;
	localparam logic [7:0] ADDR_SNVS_CFG = 8'h00_DA;
	localparam logic [7:0] ADDR_BUCK_OV_BYP = 8'h00_DB;
	localparam logic [7:0] ADDR_LIN_OV_BYP = 8'h00_DC;
	localparam logic [7:0] ADDR_BUCK_UV_BYP = 8'h00_DD;
	localparam logic [7:0] ADDR_LIN_UV_BYP = 8'h00_DE;
	localparam logic [7:0] ADDR_BUCK_IL_BYP = 8'h00_DF;
	localparam logic [7:0] ADDR_LIN_IL_BYP = 8'h00_E0;
	localparam logic [7:0] ADDR_DEBUG_REF = 8'h00_E3;
	// page 0 registers of this block
	localparam logic [7:0] ADDR_FLAGS = 8'h00_10;
	localparam logic [7:0] ADDR_CTRL = 8'h00_11;
	localparam logic [7:0] ADDR_AB_BUCK_OV = 8'h00_12;
	localparam logic [7:0] ADDR_AB_LIN_OV = 8'h00_13;
	localparam logic [7:0] ADDR_AB_BUCK_UV = 8'h00_14;
	localparam logic [7:0] ADDR_AB_LIN_UV = 8'h00_15;
	localparam logic [7:0] ADDR_PAGE = 8'h00_16;
	localparam logic [2:0] PAGE_MIRROR = 3'h1;
	localparam logic [6:0] TEMP_I2C_ADDR = 7'h08;
	localparam int FLAG_TRIM = 0;
	localparam int FLAG_FUSE = 1;
	localparam int FLAG_STEST = 2;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_REF_INT = 1;
	localparam int CTRL_REF_MASK = 2;
	localparam int CTRL_REF_STAT = 3;
	localparam int CTRL_BURN = 4;
	localparam int BYPASS_BIT = 0;
	localparam int CLK_HZ = 10_000_000;
	localparam int BLANK_MAX_US = 200;
	localparam int BLANK_CYCLES = BLANK_MAX_US * (CLK_HZ / 1_000_000);
	localparam int CHECK_CYCLES = 16;
	localparam logic [7:0] RD_NONE = 8'h00_00;

	typedef enum {ST_OFF, ST_FUSE_LOAD, ST_FUNC_LOAD, ST_SELFTEST, ST_QUIET_OFF, ST_ON} ctrl_e;

	typedef struct packed {
		logic [7:0] buck_ov;
		logic [7:0] lin_ov;
		logic [7:0] buck_uv;
		logic [7:0] lin_uv;
	} check_result_s;

	typedef logic [7:0] byte_t;
endpackage : fuse_cfg_pkg

/* fuse_config_load_and_selftest.sv */
// fuse load sequencer, temporary configuration mode, reference monitor and comparator check
// assumes the i2c target decodes frames into the register port and fuse data arrive whole
`timescale 1ns/1ps
`default_nettype none
module fuse_config_load_and_selftest
	import fuse_cfg_pkg::*;
	#(
	parameter int BLANK_LIMIT = BLANK_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic INPUT_SUPPLY_OK,
	input wire logic TEMP_CONFIG_ENABLE_PIN,
	input wire logic [NUM_MIRROR*8-1:0] FUSE_DATA,
	input wire logic TRIM_LOAD_FAIL,
	input wire logic FUSE_LOAD_FAIL,
	input wire logic LOW_POWER_OFF_SELECT,
	input wire logic POWER_UP_REQ,
	input wire logic REFERENCE_MISMATCH,
	input wire logic SAFETY_VARIANT,
	input wire logic SECURE_WRITE_ENABLE,
	input wire logic SECURE_WRITE_OK,
	input wire check_result_s CMP_FAIL,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_REFUSED,
	output logic [NUM_MIRROR*8-1:0] FUNC_CONFIG,
	output logic [6:0] I2C_ADDR_SEL,
	output logic CRC_ENABLE,
	output logic WATCHDOG_ENABLE,
	output logic REGULATORS_ON,
	output logic FAULT_BLANK,
	output logic REFERENCE_FAIL_IRQ,
	output logic FUSE_BURN_ALLOW,
	output logic QUIET_OFF
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] vin_s_q;
	logic [2:0] pin_s_q;
	logic [2:0] ref_s_q;
	logic vin_ok_q;
	logic pin_q;
	logic ref_bad_q;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			vin_s_q <= 3'h0;
			pin_s_q <= 3'h0;
			ref_s_q <= 3'h0;
		end else begin
			vin_s_q <= {vin_s_q[1:0], INPUT_SUPPLY_OK};
			pin_s_q <= {pin_s_q[1:0], TEMP_CONFIG_ENABLE_PIN};
			ref_s_q <= {ref_s_q[1:0], REFERENCE_MISMATCH};
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			vin_ok_q <= 1'b0;
			pin_q <= 1'b0;
			ref_bad_q <= 1'b0;
		end else begin
			if (vin_s_q[1] == vin_s_q[2]) vin_ok_q <= vin_s_q[2];
			if (pin_s_q[1] == pin_s_q[2]) pin_q <= pin_s_q[2];
			if (ref_s_q[1] == ref_s_q[2]) ref_bad_q <= ref_s_q[2];
		end
	end
	logic vin_rise;
	logic vin_fall;
	assign vin_rise = vin_s_q[1] && vin_s_q[2] && !vin_ok_q;
	assign vin_fall = !vin_s_q[1] && !vin_s_q[2] && vin_ok_q;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	ctrl_e state_q;
	logic [2:0] flags_q;
	logic check_run_q;
	logic [7:0] page_q;
	byte_t mirror_q [NUM_MIRROR];
	logic any_flag;
	assign any_flag = |flags_q;
	logic stest_bad;
	assign stest_bad = (ref_bad_q && SAFETY_VARIANT) || (CMP_FAIL != '0);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= ST_OFF;
		end else if (vin_fall) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: if (vin_rise) state_q <= ST_FUSE_LOAD;
				ST_FUSE_LOAD: state_q <= ST_FUNC_LOAD;
				ST_FUNC_LOAD: state_q <= ST_SELFTEST;
				ST_SELFTEST: begin
					if (pin_q || LOW_POWER_OFF_SELECT || stest_bad || any_flag || ref_bad_q) begin
						state_q <= ST_QUIET_OFF;
					end else begin
						state_q <= ST_ON;
					end
				end
				ST_QUIET_OFF: begin
					if (POWER_UP_REQ && !any_flag && !ref_bad_q) state_q <= ST_ON;
				end
				ST_ON: if (ref_bad_q && !mirror_q[8][BYPASS_BIT]) state_q <= ST_QUIET_OFF;
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// ----------------------------------------
	// mirror and functional registers
	// ----------------------------------------
	function automatic int mirror_index(input logic [7:0] a);
		if (a == ADDR_LDO3_CFG) return 0;
		else if (a == ADDR_SNVS_CFG) return 1;
		else if (a == ADDR_BUCK_OV_BYP) return 2;
		else if (a == ADDR_LIN_OV_BYP) return 3;
		else if (a == ADDR_BUCK_UV_BYP) return 4;
		else if (a == ADDR_LIN_UV_BYP) return 5;
		else if (a == ADDR_BUCK_IL_BYP) return 6;
		else if (a == ADDR_LIN_IL_BYP) return 7;
		else if (a == ADDR_DEBUG_REF) return 8;
		else return -1;
	endfunction : mirror_index

	logic ext_page;
	logic ext_ok;
	assign ext_page = (page_q[2:0] != 3'h0) && (REG_ADDR != ADDR_PAGE);
	assign ext_ok = pin_q && (page_q[2:0] == PAGE_MIRROR) && (mirror_index(REG_ADDR) >= 0);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_MIRROR; gi++) begin : g_mirror
			always_ff @(posedge CORE_CLK) begin
				if (RST || vin_fall) begin
					mirror_q[gi] <= 8'h00_00;
				end else if (state_q == ST_FUSE_LOAD) begin
					mirror_q[gi] <= FUSE_DATA[gi*8 +: 8];
				end else if (REG_WR && ext_ok && mirror_index(REG_ADDR) == gi) begin
					mirror_q[gi] <= REG_WDATA;
				end
			end
			always_ff @(posedge CORE_CLK) begin
				if (RST) FUNC_CONFIG[gi*8 +: 8] <= 8'h00_00;
				else if (state_q == ST_FUNC_LOAD) FUNC_CONFIG[gi*8 +: 8] <= mirror_q[gi];
			end
		end
	endgenerate

	// ----------------------------------------
	// page, flags, control
	// ----------------------------------------
	logic wr_page0;
	assign wr_page0 = REG_WR && !ext_page;
	always_ff @(posedge CORE_CLK) begin
		if (RST) page_q <= 8'h00_00;
		else if (wr_page0 && REG_ADDR == ADDR_PAGE) page_q <= REG_WDATA;
	end

	logic flag_clr_ok;
	assign flag_clr_ok = wr_page0 && REG_ADDR == ADDR_FLAGS && pin_q && state_q == ST_QUIET_OFF;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			flags_q <= 3'h0;
		end else begin
			if (flag_clr_ok) flags_q <= flags_q & ~REG_WDATA[2:0];
			// set wins over clear
			if (state_q == ST_FUSE_LOAD && TRIM_LOAD_FAIL) flags_q[FLAG_TRIM] <= 1'b1;
			if (state_q == ST_FUSE_LOAD && FUSE_LOAD_FAIL) flags_q[FLAG_FUSE] <= 1'b1;
			if (state_q == ST_SELFTEST) flags_q[FLAG_STEST] <= stest_bad;
		end
	end

	// ----------------------------------------
	// reference monitor
	// ----------------------------------------
	logic ref_mask_q;
	logic ref_irq_q;
	logic ref_bad_d1_q;
	logic wr_ctrl;
	assign wr_ctrl = wr_page0 && REG_ADDR == ADDR_CTRL;
	always_ff @(posedge CORE_CLK) begin
		if (RST) ref_bad_d1_q <= 1'b0;
		else ref_bad_d1_q <= ref_bad_q;
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST) ref_mask_q <= 1'b0;
		else if (wr_ctrl) ref_mask_q <= REG_WDATA[CTRL_REF_MASK];
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST) ref_irq_q <= 1'b0;
		else if (ref_bad_q && !ref_bad_d1_q && !ref_mask_q) ref_irq_q <= 1'b1;
		else if (wr_ctrl && REG_WDATA[CTRL_REF_INT]) ref_irq_q <= 1'b0;
	end

	// ----------------------------------------
	// comparator check
	// ----------------------------------------
	check_result_s result_q;
	logic [$clog2(BLANK_CYCLES+1)-1:0] chk_cnt_q;
	logic run_req;
	logic chk_done;
	logic sec_ok;
	assign sec_ok = !SECURE_WRITE_ENABLE || pin_q || SECURE_WRITE_OK;
	assign run_req = wr_ctrl && REG_WDATA[CTRL_RUN] && sec_ok && !check_run_q;
	assign chk_done = check_run_q && (chk_cnt_q == ($bits(chk_cnt_q))'(CHECK_CYCLES - 1));
	always_ff @(posedge CORE_CLK) begin
		if (RST) check_run_q <= 1'b0;
		else if (run_req) check_run_q <= 1'b1;
		else if (chk_done) check_run_q <= 1'b0;
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST || !check_run_q) chk_cnt_q <= '0;
		else chk_cnt_q <= chk_cnt_q + 1'b1;
	end
	logic res_clr;
	assign res_clr = wr_page0 && sec_ok && REG_ADDR >= ADDR_AB_BUCK_OV && REG_ADDR <= ADDR_AB_LIN_UV;
	always_ff @(posedge CORE_CLK) begin
		if (RST) result_q <= '0;
		else if (state_q == ST_SELFTEST || chk_done) result_q <= CMP_FAIL;
		else if (res_clr) begin
			if (REG_ADDR == ADDR_AB_BUCK_OV) result_q.buck_ov <= 8'h00_00;
			else if (REG_ADDR == ADDR_AB_LIN_OV) result_q.lin_ov <= 8'h00_00;
			else if (REG_ADDR == ADDR_AB_BUCK_UV) result_q.buck_uv <= 8'h00_00;
			else result_q.lin_uv <= 8'h00_00;
		end
	end

	// ----------------------------------------
	// read port and outputs
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			REG_RDATA <= RD_NONE;
			REG_REFUSED <= 1'b0;
		end else begin
			REG_REFUSED <= (REG_RD || REG_WR) && ext_page && !ext_ok;
			if (!REG_RD) REG_RDATA <= REG_RDATA;
			else if (ext_page) REG_RDATA <= ext_ok ? mirror_q[mirror_index(REG_ADDR)] : RD_NONE;
			else if (REG_ADDR == ADDR_FLAGS) REG_RDATA <= {5'h0, flags_q};
			else if (REG_ADDR == ADDR_CTRL)
				REG_RDATA <= {3'h0, FUSE_BURN_ALLOW, ref_bad_q, ref_mask_q, ref_irq_q, check_run_q};
			else if (REG_ADDR == ADDR_AB_BUCK_OV) REG_RDATA <= result_q.buck_ov;
			else if (REG_ADDR == ADDR_AB_LIN_OV) REG_RDATA <= result_q.lin_ov;
			else if (REG_ADDR == ADDR_AB_BUCK_UV) REG_RDATA <= result_q.buck_uv;
			else if (REG_ADDR == ADDR_AB_LIN_UV) REG_RDATA <= result_q.lin_uv;
			else if (REG_ADDR == ADDR_PAGE) REG_RDATA <= page_q;
			else REG_RDATA <= RD_NONE;
		end
	end

	assign I2C_ADDR_SEL = pin_q ? TEMP_I2C_ADDR : 7'h00;
	assign CRC_ENABLE = !pin_q;
	assign WATCHDOG_ENABLE = !pin_q && state_q == ST_ON;
	assign REGULATORS_ON = state_q == ST_ON;
	assign FAULT_BLANK = check_run_q;
	assign REFERENCE_FAIL_IRQ = ref_irq_q;
	assign FUSE_BURN_ALLOW = pin_q && state_q == ST_QUIET_OFF;
	assign QUIET_OFF = state_q == ST_QUIET_OFF;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [$clog2(BLANK_LIMIT+1)-1:0] blank_len_q;
	always_ff @(posedge CORE_CLK) begin
		if (RST || !FAULT_BLANK) blank_len_q <= '0;
		else if (blank_len_q != '1) blank_len_q <= blank_len_q + 1'b1;
	end
	property p_fuse_copy;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_FUSE_LOAD && !vin_fall) |=> (mirror_q[0] == $past(FUSE_DATA[7:0]));
	endproperty
	a_fuse_copy: assert property (p_fuse_copy) else $error("mirror not loaded from fuses");
	property p_func_copy;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_FUNC_LOAD) |=> (FUNC_CONFIG[7:0] == $past(mirror_q[0]));
	endproperty
	a_func_copy: assert property (p_func_copy) else $error("functional copy wrong");
	property p_mirror_locked;
		@(posedge CORE_CLK) disable iff (RST)
		(!pin_q && state_q == ST_ON && !vin_fall) |=> $stable(mirror_q[1]);
	endproperty
	a_mirror_locked: assert property (p_mirror_locked) else $error("mirror changed");
	property p_flag_block;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_QUIET_OFF && any_flag && !vin_fall) |=> state_q != ST_ON;
	endproperty
	a_flag_block: assert property (p_flag_block) else $error("power up with flag");
	property p_flag_lock;
		@(posedge CORE_CLK) disable iff (RST)
		(!pin_q && state_q != ST_FUSE_LOAD && state_q != ST_SELFTEST)
			|=> ((flags_q & $past(flags_q)) == $past(flags_q));
	endproperty
	a_flag_lock: assert property (p_flag_lock) else $error("flag cleared");
	property p_temp_quiet;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_SELFTEST && pin_q && !vin_fall) |=> state_q == ST_QUIET_OFF;
	endproperty
	a_temp_quiet: assert property (p_temp_quiet) else $error("no quiet off");
	property p_addr;
		@(posedge CORE_CLK) disable iff (RST)
		pin_q |-> (I2C_ADDR_SEL == 7'h08 && !CRC_ENABLE && !WATCHDOG_ENABLE);
	endproperty
	a_addr: assert property (p_addr) else $error("temporary mode settings");
	property p_refuse;
		@(posedge CORE_CLK) disable iff (RST)
		(REG_RD && ext_page && !pin_q) |=> REG_REFUSED;
	endproperty
	a_refuse: assert property (p_refuse) else $error("extended page not refused");
	property p_blank;
		@(posedge CORE_CLK) disable iff (RST)
		FAULT_BLANK |-> (blank_len_q < ($bits(blank_len_q))'(BLANK_LIMIT));
	endproperty
	a_blank: assert property (p_blank) else $error("blanking too long");
	property p_shut;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_ON && ref_bad_q && !mirror_q[8][0] && !vin_fall) |=> !REGULATORS_ON;
	endproperty
	a_shut: assert property (p_shut) else $error("no shutdown on drift");
	property p_stest_flag;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_SELFTEST) |=> (flags_q[FLAG_STEST] == $past(stest_bad));
	endproperty
	a_stest_flag: assert property (p_stest_flag) else $error("selftest flag wrong");
	property p_mirror_clear;
		@(posedge CORE_CLK) disable iff (RST)
		vin_fall |=> (mirror_q[0] == 8'h00_00 && mirror_q[8] == 8'h00_00);
	endproperty
	a_mirror_clear: assert property (p_mirror_clear) else $error("mirror not reset");
	property p_ref_block;
		@(posedge CORE_CLK) disable iff (RST)
		(ref_bad_q && state_q != ST_ON) |=> !REGULATORS_ON;
	endproperty
	a_ref_block: assert property (p_ref_block) else $error("power up with mismatch");
	property p_ref_irq;
		@(posedge CORE_CLK) disable iff (RST)
		(ref_bad_q && !ref_bad_d1_q && !ref_mask_q) |=> REFERENCE_FAIL_IRQ;
	endproperty
	a_ref_irq: assert property (p_ref_irq) else $error("reference irq not latched");
	property p_ref_status;
		@(posedge CORE_CLK) disable iff (RST)
		(REG_RD && !ext_page && REG_ADDR == ADDR_CTRL)
			|=> (REG_RDATA[CTRL_REF_STAT] == $past(ref_bad_q));
	endproperty
	a_ref_status: assert property (p_ref_status) else $error("reference status wrong");
	property p_selftest_result;
		@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_SELFTEST) |=> (result_q == $past(CMP_FAIL));
	endproperty
	a_selftest_result: assert property (p_selftest_result) else $error("results not loaded");
	property p_check_done;
		@(posedge CORE_CLK) disable iff (RST)
		chk_done |=> (!FAULT_BLANK && result_q == $past(CMP_FAIL));
	endproperty
	a_check_done: assert property (p_check_done) else $error("check end wrong");
	property p_flag_clear;
		@(posedge CORE_CLK) disable iff (RST)
		flag_clr_ok |=> ((flags_q & $past(REG_WDATA[2:0])) == 3'h0);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
	c_on: cover property (@(posedge CORE_CLK) disable iff (RST) state_q == ST_ON);
	c_check: cover property (@(posedge CORE_CLK) disable iff (RST) chk_done);
	c_refirq: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(ref_irq_q));
	c_refused: cover property (@(posedge CORE_CLK) disable iff (RST) REG_REFUSED);
	c_flag_clear: cover property (@(posedge CORE_CLK) disable iff (RST) flag_clr_ok);
endmodule : fuse_config_load_and_selftest
`default_nettype wire

/* host_model.sv */
// host side of the register port: register write and read cycles
// assumes the bench calls wr and rd one at a time, inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model
	import fuse_cfg_pkg::*;
(
	input wire logic CORE_CLK,
	output logic [7:0] REG_ADDR,
	output logic REG_WR,
	output logic REG_RD,
	output logic [7:0] REG_WDATA,
	output logic SECURE_WRITE_OK
);
	initial begin
		REG_ADDR = 8'h00_00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_WDATA = 8'h00_00;
		SECURE_WRITE_OK = 1'b0;
	end
	// every write goes out as a secure write
	task automatic wr(input byte_t a, input byte_t d);
		@(negedge CORE_CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		SECURE_WRITE_OK = 1'b1;
		@(negedge CORE_CLK);
		REG_WR = 1'b0;
		SECURE_WRITE_OK = 1'b0;
		REG_WDATA = ~d;
	endtask : wr
	task automatic rd(input byte_t a);
		@(negedge CORE_CLK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CORE_CLK);
		REG_RD = 1'b0;
		REG_ADDR = ~a;
	endtask : rd
endmodule : host_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the fuse loader, temporary mode, reference monitor and check
// assumes host_model drives the register port and reads answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fuse_cfg_pkg::*;
	typedef struct packed {logic refused; byte_t data;} rd_exp_s;
	logic CORE_CLK = 1'b0, RST = 1'b1, INPUT_SUPPLY_OK = 1'b0, TEMP_CONFIG_ENABLE_PIN = 1'b0;
	logic [NUM_MIRROR*8-1:0] FUSE_DATA = '0;
	logic TRIM_LOAD_FAIL = 1'b0, FUSE_LOAD_FAIL = 1'b0, LOW_POWER_OFF_SELECT = 1'b0;
	logic POWER_UP_REQ = 1'b0, REFERENCE_MISMATCH = 1'b0, SAFETY_VARIANT = 1'b0;
	logic SECURE_WRITE_ENABLE = 1'b0, SECURE_WRITE_OK, REG_WR, REG_RD, rd_pend = 1'b0;
	check_result_s CMP_FAIL = '0;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic REG_REFUSED, CRC_ENABLE, WATCHDOG_ENABLE, REGULATORS_ON, FAULT_BLANK;
	logic REFERENCE_FAIL_IRQ, FUSE_BURN_ALLOW, QUIET_OFF;
	logic [NUM_MIRROR*8-1:0] FUNC_CONFIG;
	logic [6:0] I2C_ADDR_SEL;
	rd_exp_s exp_q[$];
	rd_exp_s e;
	int num_errors = 0, n_compared = 0, cycles = 0, n;
	byte_t v;
	always #50 CORE_CLK = ~CORE_CLK;
	host_model i_host_model (.CORE_CLK(CORE_CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .SECURE_WRITE_OK(SECURE_WRITE_OK));
	fuse_config_load_and_selftest #(.BLANK_LIMIT(BLANK_CYCLES)) i_fuse_config_load_and_selftest (
		.CORE_CLK(CORE_CLK), .RST(RST), .INPUT_SUPPLY_OK(INPUT_SUPPLY_OK),
		.TEMP_CONFIG_ENABLE_PIN(TEMP_CONFIG_ENABLE_PIN), .FUSE_DATA(FUSE_DATA),
		.TRIM_LOAD_FAIL(TRIM_LOAD_FAIL), .FUSE_LOAD_FAIL(FUSE_LOAD_FAIL),
		.LOW_POWER_OFF_SELECT(LOW_POWER_OFF_SELECT), .POWER_UP_REQ(POWER_UP_REQ),
		.REFERENCE_MISMATCH(REFERENCE_MISMATCH), .SAFETY_VARIANT(SAFETY_VARIANT),
		.SECURE_WRITE_ENABLE(SECURE_WRITE_ENABLE), .SECURE_WRITE_OK(SECURE_WRITE_OK),
		.CMP_FAIL(CMP_FAIL), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_REFUSED(REG_REFUSED),
		.FUNC_CONFIG(FUNC_CONFIG), .I2C_ADDR_SEL(I2C_ADDR_SEL), .CRC_ENABLE(CRC_ENABLE),
		.WATCHDOG_ENABLE(WATCHDOG_ENABLE), .REGULATORS_ON(REGULATORS_ON),
		.FAULT_BLANK(FAULT_BLANK), .REFERENCE_FAIL_IRQ(REFERENCE_FAIL_IRQ),
		.FUSE_BURN_ALLOW(FUSE_BURN_ALLOW), .QUIET_OFF(QUIET_OFF));
	// ----------------------------------------
	// compare tasks and result watcher
	// ----------------------------------------
	task automatic chk_port(input string nm, input logic [71:0] ex, input logic [71:0] got);
		n_compared++;
		if (got !== ex) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk_port
	task automatic cmp_rd(input rd_exp_s ex, input rd_exp_s got);
		n_compared++;
		if (got !== ex) begin
			num_errors++;
			$display("MISMATCH read expected %h seen %h", ex, got);
		end
	endtask : cmp_rd
	always @(posedge CORE_CLK) rd_pend <= REG_RD;
	always @(negedge CORE_CLK) begin
		if (rd_pend === 1'b1) begin
			e = exp_q.pop_front();
			cmp_rd(e, {REG_REFUSED, REG_RDATA});
		end
	end
	task automatic rd(input byte_t a, input logic refused, input byte_t d);
		exp_q.push_back({refused, d});
		i_host_model.rd(a);
	endtask : rd
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge CORE_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(82));
		FUSE_DATA = {8'($urandom), 32'($urandom), 32'($urandom)};
		CMP_FAIL = $urandom;
		repeat (2) @(negedge CORE_CLK);
		RST = 1'b0;
		// power-up load in temporary mode with a fuse load failure
		TEMP_CONFIG_ENABLE_PIN = 1'b1;
		FUSE_LOAD_FAIL = 1'b1;
		repeat (5) @(negedge CORE_CLK);
		INPUT_SUPPLY_OK = 1'b1;
		for (n = 0; n < 40 && QUIET_OFF !== 1'b1; n++) @(negedge CORE_CLK);
		FUSE_LOAD_FAIL = 1'b0;
		chk_port("quiet_off", 1, QUIET_OFF);
		chk_port("func_config", FUSE_DATA, FUNC_CONFIG);
		chk_port("i2c_addr", TEMP_I2C_ADDR, I2C_ADDR_SEL);
		chk_port("crc", 0, CRC_ENABLE);
		chk_port("watchdog", 0, WATCHDOG_ENABLE);
		chk_port("burn_allow", 1, FUSE_BURN_ALLOW);
		$display("test load done");
		// failure flag blocks power-up until cleared; selftest flag shows the real result
		rd(ADDR_FLAGS, 1'b0, {5'h00, CMP_FAIL != '0, 1'h1, 1'h0});
		POWER_UP_REQ = 1'b1;
		repeat (6) @(negedge CORE_CLK);
		POWER_UP_REQ = 1'b0;
		chk_port("regulators_on", 0, REGULATORS_ON);
		i_host_model.wr(ADDR_FLAGS, 8'h00_07);
		rd(ADDR_FLAGS, 1'b0, 8'h00_00);
		$display("test flags done");
		// mirror page access and modification
		i_host_model.wr(ADDR_PAGE, 8'h00_01);
		rd(ADDR_LDO3_CFG, 1'b0, FUSE_DATA[7:0]);
		rd(ADDR_DEBUG_REF, 1'b0, FUSE_DATA[71:64]);
		v = $urandom;
		i_host_model.wr(ADDR_SNVS_CFG, v);
		rd(ADDR_SNVS_CFG, 1'b0, v);
		i_host_model.wr(ADDR_PAGE, 8'h00_00);
		$display("test mirror done");
		// on-demand comparator check
		i_host_model.wr(ADDR_CTRL, 8'h00_01);
		chk_port("blank_start", 1, FAULT_BLANK);
		for (n = 0; n < BLANK_CYCLES && FAULT_BLANK !== 1'b0; n++) @(negedge CORE_CLK);
		chk_port("blank_end", 0, FAULT_BLANK);
		rd(ADDR_AB_BUCK_OV, 1'b0, CMP_FAIL.buck_ov);
		rd(ADDR_AB_LIN_OV, 1'b0, CMP_FAIL.lin_ov);
		rd(ADDR_AB_BUCK_UV, 1'b0, CMP_FAIL.buck_uv);
		rd(ADDR_AB_LIN_UV, 1'b0, CMP_FAIL.lin_uv);
		rd(ADDR_CTRL, 1'b0, 8'h00_10);
		$display("test check done");
		// reference mismatch status and interrupt latch
		REFERENCE_MISMATCH = 1'b1;
		repeat (6) @(negedge CORE_CLK);
		chk_port("ref_irq", 1, REFERENCE_FAIL_IRQ);
		rd(ADDR_CTRL, 1'b0, 8'h00_1A);
		REFERENCE_MISMATCH = 1'b0;
		repeat (6) @(negedge CORE_CLK);
		i_host_model.wr(ADDR_CTRL, 8'h00_02);
		rd(ADDR_CTRL, 1'b0, 8'h00_10);
		$display("test reference done");
		// supply loss resets mirrors, pin low refuses extended pages
		i_host_model.wr(ADDR_PAGE, 8'h00_01);
		INPUT_SUPPLY_OK = 1'b0;
		repeat (6) @(negedge CORE_CLK);
		rd(ADDR_SNVS_CFG, 1'b0, 8'h00_00);
		TEMP_CONFIG_ENABLE_PIN = 1'b0;
		repeat (6) @(negedge CORE_CLK);
		rd(ADDR_LDO3_CFG, 1'b1, RD_NONE);
		i_host_model.wr(ADDR_FLAGS, 8'h00_07);
		chk_port("burn_off", 0, FUSE_BURN_ALLOW);
		$display("test supply loss done");
		// pin held low at power-up gives full function; drift with bypass 0 shuts down
		i_host_model.wr(ADDR_PAGE, 8'h00_00);
		CMP_FAIL = '0;
		FUSE_DATA[64] = 1'b0;
		INPUT_SUPPLY_OK = 1'b1;
		for (n = 0; n < 40 && REGULATORS_ON !== 1'b1; n++) @(negedge CORE_CLK);
		chk_port("regulators_up", 1, REGULATORS_ON);
		chk_port("crc_full", 1, CRC_ENABLE);
		chk_port("watchdog_full", 1, WATCHDOG_ENABLE);
		chk_port("i2c_addr_full", 0, I2C_ADDR_SEL);
		i_host_model.wr(ADDR_CTRL, 8'h00_04);
		REFERENCE_MISMATCH = 1'b1;
		repeat (6) @(negedge CORE_CLK);
		chk_port("drift_off", 0, REGULATORS_ON);
		chk_port("irq_masked", 0, REFERENCE_FAIL_IRQ);
		rd(ADDR_FLAGS, 1'b0, 8'h00_00);
		$display("test full power-up done");
		repeat (3) @(negedge CORE_CLK);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
